// ===== core/pzc_ctrl.sv
/*
 * One-wire enable, drive and shutdown control for a piezo driver.
 * Assumes the one-wire input is synchronous to core_clk_i.
 */
`timescale 1ns/10ps
// Contract
// [R1] First rising edge turns pump on
// [R2] Second rising edge enables true output
// [R3] Inverted output complements, same cycle
// [R4] Single edge then high: pump only
// [R5] Disabled driver holds both outputs low
// [R6] Continuous low disables within 50 ms
// [R7] Timeout not under 5 ms, nominal 15
// [R8] After shutdown, restart from first edge
// [R9] Selects ignored while input low
// [R10] Selects choose off, 1x, 2x, 3x
// [R11] Host keeps low phases under 5 ms
// [R12] Low counter cleared on each rise
// [R13] States off, pump-only, driving
module pzc_ctrl #(
	parameter int unsigned TIMEOUT_CYCLES = pzc_pkg::SHUTDOWN_CYCLES
) (
	input wire logic core_clk_i, // Core clock, 100 MHz.
	input wire logic resetn_i, // Async reset, active low.
	input wire logic clk_en_i, // Clock enable, freezes state.
	input wire logic wire_in_i, // One-wire audio and enable input.
	input wire logic pump_sel_a_i, // Pump mode select a.
	input wire logic pump_sel_b_i, // Pump mode select b.
	output logic drive_out_true_o, // True driver output.
	output logic drive_out_inverted_o, // Inverted driver output.
	output logic pump_on_o, // Charge pump enabled.
	output pzc_pkg::pzc_pump_type pump_mode_o, // Boosted rail mode.
	output logic driver_en_o // Driver stage enabled.
);
	pzc_pkg::pzc_state_type st_q;
	pzc_pkg::pzc_state_type st_d;
	logic prev_q;
	logic prev_d;
	logic rise;
	pzc_pkg::pzc_pump_type mode_q;
	pzc_pkg::pzc_pump_type mode_d;
	logic t_q;
	logic t_d;
	logic n_q;
	logic n_d;
	pzc_tmr_if tif ();

	// ------------------------------------------------------------------
	// Edge detect and low timer
	// ------------------------------------------------------------------
	assign rise = wire_in_i && !prev_q;
	assign tif.clear = rise; // R12
	assign tif.low = !wire_in_i;

	pzc_low_timer #(
		.TIMEOUT_CYCLES(TIMEOUT_CYCLES)
	) u_tmr (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.clk_en_i(clk_en_i),
		.tmr(tif)
	);

	function automatic pzc_pkg::pzc_pump_type dec_mode(
		input logic a, input logic b);
		unique case ({a, b})
			pzc_pkg::SEL_OFF: dec_mode = pzc_pkg::PZC_PUMP_OFF;
			pzc_pkg::SEL_X1: dec_mode = pzc_pkg::PZC_PUMP_X1;
			pzc_pkg::SEL_X2: dec_mode = pzc_pkg::PZC_PUMP_X2;
			pzc_pkg::SEL_X3: dec_mode = pzc_pkg::PZC_PUMP_X3;
		endcase
	endfunction : dec_mode

	// ------------------------------------------------------------------
	// State and outputs
	// ------------------------------------------------------------------
	always_comb begin
		prev_d = wire_in_i;
		st_d = st_q;
		unique case (st_q)
			pzc_pkg::PZC_ST_OFF: begin
				if (rise) begin
					st_d = pzc_pkg::PZC_ST_PUMP; // R1 R8 R13
				end
			end
			pzc_pkg::PZC_ST_PUMP: begin
				if (tif.expired) begin
					st_d = pzc_pkg::PZC_ST_OFF; // R6
				end else if (rise) begin
					st_d = pzc_pkg::PZC_ST_DRIVE; // R2 R13
				end
			end
			pzc_pkg::PZC_ST_DRIVE: begin
				if (tif.expired) begin
					st_d = pzc_pkg::PZC_ST_OFF; // R6 R13
				end
			end
		endcase
		// Low phases are short while the host keeps to its spacing, so the
		// selects stay valid; a held low freezes the last mode until shutdown forces it off.
		mode_d = mode_q; // R9 R11
		if (wire_in_i) begin
			mode_d = dec_mode(pump_sel_a_i, pump_sel_b_i); // R10
		end
		if (st_d == pzc_pkg::PZC_ST_OFF) begin
			mode_d = pzc_pkg::PZC_PUMP_OFF;
		end
		t_d = 1'b0; // R5
		n_d = 1'b0; // R5
		if (st_d == pzc_pkg::PZC_ST_DRIVE) begin
			t_d = wire_in_i; // R2
			n_d = !wire_in_i; // R3
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= pzc_pkg::PZC_ST_OFF;
			prev_q <= 1'b0;
			mode_q <= pzc_pkg::PZC_PUMP_OFF;
			t_q <= 1'b0;
			n_q <= 1'b0;
		end else if (clk_en_i) begin
			st_q <= st_d;
			prev_q <= prev_d;
			mode_q <= mode_d;
			t_q <= t_d;
			n_q <= n_d;
		end
	end

	assign drive_out_true_o = t_q;
	assign drive_out_inverted_o = n_q;
	assign pump_on_o = (st_q != pzc_pkg::PZC_ST_OFF) &&
		(mode_q != pzc_pkg::PZC_PUMP_OFF); // R4 R10
	assign pump_mode_o = mode_q;
	assign driver_en_o = (st_q == pzc_pkg::PZC_ST_DRIVE);
endmodule : pzc_ctrl

// ===== core/pzc_low_timer.sv
/*
 * Low-time counter for the one-wire input.
 * Assumes the controller pulses clear on every rising edge.
 */
`timescale 1ns/10ps
module pzc_low_timer #(
	parameter int unsigned TIMEOUT_CYCLES = pzc_pkg::SHUTDOWN_CYCLES
) (
	input wire logic core_clk_i, // Core clock.
	input wire logic resetn_i, // Async reset, active low.
	input wire logic clk_en_i, // Clock enable.
	pzc_tmr_if.tmr tmr // Timer side.
);
	logic [pzc_pkg::CNT_W-1:0] cnt_q;
	logic [pzc_pkg::CNT_W-1:0] cnt_d;
	logic exp_q;
	logic exp_d;

	always_comb begin
		cnt_d = cnt_q;
		exp_d = exp_q;
		if (tmr.clear || !tmr.low) begin // R12
			cnt_d = '0;
			exp_d = 1'b0;
		end else if (cnt_q >= pzc_pkg::CNT_W'(TIMEOUT_CYCLES - 1)) begin
			exp_d = 1'b1; // R6 R7
		end else begin
			cnt_d = cnt_q + pzc_pkg::CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= '0;
			exp_q <= 1'b0;
		end else if (clk_en_i) begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign tmr.expired = exp_q;
endmodule : pzc_low_timer

// ===== dv/pzc_checker.sv
/* Port assertions for pzc_ctrl, bound into every instance.
   Assumes the one-wire input is sampled on each core clock edge. */
`timescale 1ns/10ps
module pzc_checker #(
	parameter int unsigned TIMEOUT_CYCLES = 50
) (
	input wire logic core_clk_i, // Clock.
	input wire logic resetn_i, // Reset.
	input wire logic clk_en_i, // Clock enable.
	input wire logic wire_in_i, // One-wire input.
	input wire logic pump_sel_a_i, // Select a.
	input wire logic pump_sel_b_i, // Select b.
	input wire logic drive_out_true_o, // True output.
	input wire logic drive_out_inverted_o, // Inverted output.
	input wire logic pump_on_o, // Pump on.
	input wire pzc_pkg::pzc_pump_type pump_mode_o, // Pump mode.
	input wire logic driver_en_o // Driver on.
);
	logic [7:0] low_d;
	logic [7:0] low_q;
	default clocking @(posedge core_clk_i); endclocking
	// A frozen design must not be held to its timing, so checks pause too.
	default disable iff (!resetn_i || !clk_en_i);
	// Saturates so a long shutdown never wraps back into range.
	always_comb begin
		low_d = low_q;
		if (wire_in_i) low_d = 8'h0;
		else if (low_q != 8'hff) low_d = low_q + 8'h1;
	end
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) low_q <= 8'h0;
		else if (clk_en_i) low_q <= low_d;
	end
	sequence s_wake;
		wire_in_i && low_q > TIMEOUT_CYCLES + 2 && (pump_sel_a_i || pump_sel_b_i);
	endsequence
	AST_INV: assert property (driver_en_o |->
		drive_out_inverted_o != drive_out_true_o) else $error("no complement");
	AST_OFF: assert property (!driver_en_o |->
		!drive_out_true_o && !drive_out_inverted_o) else $error("not grounded");
	AST_SECOND: assert property ($rose(wire_in_i) && pump_on_o |=>
		driver_en_o) else $error("driver not enabled");
	AST_MODE: assert property (driver_en_o && wire_in_i |=>
		pump_mode_o == {$past(pump_sel_a_i), $past(pump_sel_b_i)})
		else $error("wrong pump mode");
	AST_SELLOW: assert property (driver_en_o && !wire_in_i |=>
		$stable(pump_mode_o) || !driver_en_o) else $error("select used");
	AST_WAKE: assert property (s_wake |=>
		pump_on_o && !driver_en_o) else $error("bad wake");
	AST_EARLY: assert property ($fell(driver_en_o) |->
		low_q > TIMEOUT_CYCLES) else $error("early shutdown");
	AST_LATE: assert property (low_q == TIMEOUT_CYCLES + 4 |->
		!pump_on_o && !driver_en_o) else $error("late shutdown");
endmodule : pzc_checker
bind pzc_ctrl pzc_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.*);

// ===== dv/pzc_host.sv
/* Host model driving the one-wire line low, high or with a tone.
   Assumes commands change just after a rising clock edge. */
`timescale 1ns/10ps
module pzc_host (
	input wire logic core_clk_i, // Clock.
	input wire logic [1:0] cmd_i, // 0 low, 1 high, 2 tone.
	output logic wire_o // One-wire line.
);
	logic [1:0] ph_q = 2'h0;
	initial wire_o = 1'b0;
	// Tone low phases last two cycles, far short of the shutdown count.
	always @(posedge core_clk_i) begin
		ph_q <= ph_q + 2'h1;
		wire_o <= cmd_i[1] ? ph_q[1] : cmd_i[0];
	end
endmodule : pzc_host

// ===== dv/test_pzc_ctrl.sv
/* Self-checking bench for pzc_ctrl with a host model on the wire.
   Assumes the checker bind is compiled with the design. */
`timescale 1ns/10ps
module test_pzc_ctrl;
	localparam int TMO = 50;
	logic core_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic pump_sel_a_i = 1'b0;
	logic pump_sel_b_i = 1'b0;
	logic [1:0] cmd = 2'h0;
	logic wire_in_i, prev_in, drive_out_true_o, drive_out_inverted_o;
	logic pump_on_o, driver_en_o;
	pzc_pkg::pzc_pump_type pump_mode_o;
	int error_cnt = 0;
	int n_tests = 0;
	int k;
	// Rows are {select, mode, pump on}.
	logic [4:0] rows [4] = '{5'h00, 5'h0b, 5'h15, 5'h1f};
	always #5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) prev_in <= wire_in_i;
	pzc_ctrl #(.TIMEOUT_CYCLES(TMO)) dut (.*);
	pzc_host host (.core_clk_i(core_clk_i), .cmd_i(cmd), .wire_o(wire_in_i));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done
	task automatic wt(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask : wt
	initial begin
		wt(2);
		chk({drive_out_true_o, drive_out_inverted_o, driver_en_o}, 8'h0);
		@(posedge core_clk_i) resetn_i <= 1'b1;
		foreach (rows[i]) begin
			@(posedge core_clk_i) {pump_sel_a_i, pump_sel_b_i} <= rows[i][4:3];
			cmd <= 2'h2;
			wt(12);
			chk({pump_mode_o, pump_on_o, driver_en_o}, {rows[i][2:0], 1'b1});
			chk({drive_out_true_o, drive_out_inverted_o}, {prev_in, ~prev_in});
		end
		@(posedge core_clk_i) cmd <= 2'h0;
		wt(3);
		@(posedge core_clk_i) {pump_sel_a_i, pump_sel_b_i} <= 2'h1;
		wt(10);
		chk(pump_mode_o, pzc_pkg::PZC_PUMP_X3);
		for (k = 13; k < 200 && driver_en_o !== 1'b0; k++) wt(1);
		chk(k >= TMO && k <= TMO + 8, 1'b1);
		chk({drive_out_true_o, drive_out_inverted_o, pump_on_o}, 8'h0);
		if (k == 200) test_done();
		wt(4);
		@(posedge core_clk_i) cmd <= 2'h1;
		wt(10);
		chk({pump_mode_o, pump_on_o, driver_en_o, drive_out_true_o,
			drive_out_inverted_o}, 8'h18);
		// A held low longer than the timeout must not shut down a frozen core.
		@(posedge core_clk_i) clk_en_i <= 1'b0;
		cmd <= 2'h0;
		wt(80);
		@(posedge core_clk_i) cmd <= 2'h1;
		wt(2);
		@(posedge core_clk_i) clk_en_i <= 1'b1;
		wt(3);
		chk({pump_on_o, driver_en_o}, 8'h2);
		test_done();
	end
endmodule : test_pzc_ctrl

// ===== include/pzc_pkg.sv
/*
 * Constants and types for the one-wire piezo enable controller.
 * Assumes a 100 MHz core clock.
 */
package pzc_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	// ------------------------------------------------------------------
	// Shutdown timing
	// ------------------------------------------------------------------
	localparam int unsigned SHUTDOWN_TIMEOUT_MS = 15;
	localparam int unsigned SHUTDOWN_MIN_MS = 5;
	localparam int unsigned SHUTDOWN_MAX_MS = 50;
	localparam int unsigned SHUTDOWN_CYCLES =
		SHUTDOWN_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned CNT_W = 32;
	// ------------------------------------------------------------------
	// Pump mode encoding {pump_sel_a, pump_sel_b}
	// ------------------------------------------------------------------
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_X1 = 2'h1;
	localparam logic [1:0] SEL_X2 = 2'h2;
	localparam logic [1:0] SEL_X3 = 2'h3;
	typedef enum logic [1:0] {
		PZC_PUMP_OFF,
		PZC_PUMP_X1,
		PZC_PUMP_X2,
		PZC_PUMP_X3
	} pzc_pump_type;
	typedef enum logic [1:0] {
		PZC_ST_OFF,
		PZC_ST_PUMP,
		PZC_ST_DRIVE
	} pzc_state_type;
endpackage : pzc_pkg

// ===== include/pzc_tmr_if.sv
/*
 * Interface between the controller and its low-time timer.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/10ps
interface pzc_tmr_if;
	logic clear;
	logic low;
	logic expired;
	modport ctrl (output clear, output low, input expired);
	modport tmr (input clear, input low, output expired);
endinterface : pzc_tmr_if
